//--- design/dic_cmd_mem.sv
// Command string memory: eight buffers of 128 characters, registered read.
`timescale 1ns/1ns
module dic_cmd_mem (
  input wire logic clk,
  input wire logic resetn,
  dic_mem_if.mem mif
);
  logic [7:0] mem_ff [1024];
  logic [7:0] rdata_ff;

  always_ff @(posedge clk) begin
    if (mif.we) begin
      mem_ff[mif.waddr] <= mif.wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= 8'h00;
    end else if (mif.re) begin
      rdata_ff <= mem_ff[mif.raddr];
    end
  end

  assign mif.rdata = rdata_ff;
endmodule : dic_cmd_mem

//--- design/dic_consts.svh
// Offsets, sizes, reset values and timing counts of the input unit.
`ifndef DIC_CONSTS_SVH
`define DIC_CONSTS_SVH
// How it works
// - Command-buffer inputs offer four buffer sets, each with rise and fall strings.
// - A rising edge plays the rising string of the input's selected set.
// - A falling edge plays the falling string of the input's selected set; here it is dropped if that input's rise is pending at the pick.
// - Each buffer holds up to 128 characters and starts out empty.
// - The extra argument picks the set; value 1 picks the first set.
// - A read-only rotary knob value from 0 to 99 is offered.
// - Input levels form a seven-bit vector, input 1 leftmost, input 7 rightmost.
// - Filter selection 0 to 3 per input; default 1 for inputs 1-2, else 2.
// - Selection 0 applies no filtering; pulses of 40 ns or more pass; here a pulse under one 50 ns clock can be missed.
// - Selection 1 passes only pulses of at least 10.24 us.
// - Selection 2 passes only pulses of at least 163 us.
// - Selection 3 passes only pulses of at least 2.62 ms.
// - Each input has a one-bit polarity setting, default 0.
// - Polarity 0 means active high, polarity 1 means active low.

// ==========================================================================
// Sizes
`define DIC_NUM_IN 7
`define DIC_BUF_CHARS 8'h80
`define DIC_FN_CMDBUF 5'h09
`define DIC_ARG_MAX 3'h4

// ==========================================================================
// Register byte offsets
`define DIC_REG_ROTARY 8'h00
`define DIC_REG_STATES 8'h04
`define DIC_REG_FILTER 8'h08
`define DIC_REG_INV 8'h0c
`define DIC_REG_EXEC 8'h10
`define DIC_REG_CMDPTR 8'h14
`define DIC_REG_CMDDATA 8'h18
`define DIC_REG_CMDLEN 8'h1c
`define DIC_REG_CFG0 8'h20

// ==========================================================================
// Reset values
`define DIC_FILTER_RST 14'h2aa5
`define DIC_INV_RST 7'h00

// ==========================================================================
// Filter timing, times in ns and counts of 50 ns clock cycles
`define DIC_CLK_NS 50
`define DIC_F1_NS 10240
`define DIC_F2_NS 163000
`define DIC_F3_NS 2620000
`define DIC_F1_CYC ((`DIC_F1_NS + `DIC_CLK_NS - 1) / `DIC_CLK_NS)
`define DIC_F2_CYC ((`DIC_F2_NS + `DIC_CLK_NS - 1) / `DIC_CLK_NS)
`define DIC_F3_CYC ((`DIC_F3_NS + `DIC_CLK_NS - 1) / `DIC_CLK_NS)
`endif

//--- design/dic_filter.sv
// One input channel: pin synchroniser and selectable pulse-width filter.
`timescale 1ns/1ns
`include "dic_consts.svh"
module dic_filter #(
  parameter logic [15:0] F3_CYC = 16'(`DIC_F3_CYC)
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic pin,
  input wire dic_pkg::dic_filt_sel_t sel,
  output logic filt
);
  logic sync1_ff;
  logic sync2_ff;
  logic filt_ff;
  logic [15:0] cnt_ff;
  logic [15:0] need;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= pin;
      sync2_ff <= sync1_ff;
    end
  end

  always_comb begin
    unique case (sel)
      2'h1: need = 16'(`DIC_F1_CYC);
      2'h2: need = 16'(`DIC_F2_CYC);
      2'h3: need = F3_CYC;
      default: need = 16'h0001;
    endcase
  end

  // A new level is taken only after it has held for the full count.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= 16'h0000;
      filt_ff <= 1'b0;
    end else if (sel == 2'h0 || sync2_ff == filt_ff) begin
      cnt_ff <= 16'h0000;
      filt_ff <= sync2_ff;
    end else if (cnt_ff >= need - 16'h0001) begin
      cnt_ff <= 16'h0000;
      filt_ff <= sync2_ff;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  assign filt = filt_ff;

  property p_unfiltered;
    @(posedge clk) disable iff (!resetn)
    sel == 2'h0 |=> filt_ff == $past(sync2_ff);
  endproperty
  a_unfiltered: assert property (p_unfiltered)
    else $error("Unfiltered channel did not follow its input.");

  property p_held_change;
    @(posedge clk) disable iff (!resetn)
    (sel != 2'h0 && $stable(sel) && filt_ff != sync2_ff &&
      cnt_ff < need - 16'h0001) |=> $stable(filt_ff);
  endproperty
  a_held_change: assert property (p_held_change)
    else $error("Filtered level changed before the pulse was long enough.");
endmodule : dic_filter

//--- design/dic_mem_if.sv
// Port bundle between the player and the command string memory.
`timescale 1ns/1ns
interface dic_mem_if;
  logic we;
  logic [9:0] waddr;
  logic [7:0] wdata;
  logic re;
  logic [9:0] raddr;
  logic [7:0] rdata;
  modport mem (input we, input waddr, input wdata, input re, input raddr,
    output rdata);
  modport user (output we, output waddr, output wdata, output re,
    output raddr, input rdata);
endinterface : dic_mem_if

//--- design/dic_pkg.sv
// Types shared by the input conditioning modules.
package dic_pkg;
  typedef enum logic [3:0] {
    DIC_S_IDLE = 4'b0001,
    DIC_S_ADDR = 4'b0010,
    DIC_S_DATA = 4'b0100,
    DIC_S_SEND = 4'b1000
  } dic_exec_state_t;
  typedef logic [1:0] dic_filt_sel_t;
endpackage : dic_pkg

//--- design/dic_top.sv
// Digital input conditioning: filters, polarity, states, knob, command play.
//
// Our own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ns
`include "dic_consts.svh"
module dic_top #(
  parameter logic [15:0] FILT3_CYC = 16'(`DIC_F3_CYC)
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [6:0] din_pin,
  input wire logic [3:0] rot_tens_pin,
  input wire logic [3:0] rot_ones_pin,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cmd_ready,
  output logic [7:0] cmd_char,
  output logic cmd_valid,
  output logic cmd_last,
  output logic [2:0] cmd_src,
  output logic cmd_falling
);
  // ========================================================================
  // Configuration and status state
  logic [13:0] filter_sel_ff;
  logic [6:0] inv_ff;
  logic [4:0] func_ff [7];
  logic [2:0] arg_ff [7];
  logic [7:0] len_ff [8];
  logic [9:0] ptr_ff;
  logic [6:0] filt;
  logic [6:0] states_ff;
  logic [6:0] prev_ff;
  logic [6:0] active;
  logic [6:0] armed;
  logic [6:0] rise_pend_ff;
  logic [6:0] fall_pend_ff;
  logic [6:0] clr_pend;
  logic [3:0] tens_s1_ff;
  logic [3:0] tens_s2_ff;
  logic [3:0] ones_s1_ff;
  logic [3:0] ones_s2_ff;
  logic [6:0] rotary_ff;
  logic [3:0] tens_c;
  logic [3:0] ones_c;
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic [31:0] rd_mux;
  logic [31:0] wmask;
  logic wr_acc;
  logic [7:0] reg_addr;
  dic_pkg::dic_exec_state_t st_ff;
  logic [2:0] buf_ff;
  logic [6:0] idx_ff;
  logic [2:0] src_ff;
  logic [7:0] char_ff;
  logic valid_ff;
  logic last_ff;
  logic pick_ok;
  logic pick_fall;
  logic [2:0] pick_src;
  logic [2:0] pick_buf;
  logic [2:0] pick_arg;
  logic pick_go;
  dic_mem_if mif ();

  // ========================================================================
  // Input channels
  genvar g;
  generate
    for (g = 0; g < `DIC_NUM_IN; g++) begin : g_in
      dic_filter #(.F3_CYC(FILT3_CYC)) u_filt (
        .clk(clk),
        .resetn(resetn),
        .pin(din_pin[g]),
        .sel(filter_sel_ff[2*g+1:2*g]),
        .filt(filt[g])
      );
      assign active[g] = filt[g] ^ inv_ff[g];
      assign armed[g] = func_ff[g] == `DIC_FN_CMDBUF &&
        arg_ff[g] != 3'h0 && arg_ff[g] <= `DIC_ARG_MAX;
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          states_ff[6-g] <= 1'b0;
        end else begin
          states_ff[6-g] <= filt[g];
        end
      end
    end
  endgenerate

  // ========================================================================
  // Edge capture; a new event wins over the clear in the same cycle.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_ff <= 7'h00;
      rise_pend_ff <= 7'h00;
      fall_pend_ff <= 7'h00;
    end else begin
      prev_ff <= active;
      rise_pend_ff <= (rise_pend_ff & ~clr_pend) |
        (active & ~prev_ff & armed);
      fall_pend_ff <= (fall_pend_ff & ~clr_pend) |
        (~active & prev_ff & armed);
    end
  end

  // ========================================================================
  // Rotary knob, two decimal digits, each held to 9.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tens_s1_ff <= 4'h0;
      tens_s2_ff <= 4'h0;
      ones_s1_ff <= 4'h0;
      ones_s2_ff <= 4'h0;
      rotary_ff <= 7'h00;
    end else begin
      tens_s1_ff <= rot_tens_pin;
      tens_s2_ff <= tens_s1_ff;
      ones_s1_ff <= rot_ones_pin;
      ones_s2_ff <= ones_s1_ff;
      rotary_ff <= 7'({3'h0, tens_c} * 7'h0a) + {3'h0, ones_c};
    end
  end
  assign tens_c = (tens_s2_ff > 4'h9) ? 4'h9 : tens_s2_ff;
  assign ones_c = (ones_s2_ff > 4'h9) ? 4'h9 : ones_s2_ff;

  // ========================================================================
  // Avalon slave: one wait state, then waitrequest low for one cycle.
  assign reg_addr = {avs_address[7:2], 2'h0};
  assign wr_acc = avs_write && !wait_ff;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (reg_addr)
      `DIC_REG_ROTARY: rd_mux = {25'h0, rotary_ff};
      `DIC_REG_STATES: rd_mux = {25'h0, states_ff};
      `DIC_REG_FILTER: rd_mux = {18'h0, filter_sel_ff};
      `DIC_REG_INV: rd_mux = {25'h0, inv_ff};
      `DIC_REG_EXEC: rd_mux = {15'h0, st_ff != dic_pkg::DIC_S_IDLE,
        1'b0, fall_pend_ff, 1'b0, rise_pend_ff};
      `DIC_REG_CMDPTR: rd_mux = {22'h0, ptr_ff};
      `DIC_REG_CMDLEN: rd_mux = {24'h0, len_ff[ptr_ff[9:7]]};
      default: begin
        for (int i = 0; i < `DIC_NUM_IN; i++) begin
          if (reg_addr == `DIC_REG_CFG0 + 8'(4 * i)) begin
            rd_mux = {21'h0, arg_ff[i], 3'h0, func_ff[i]};
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else if (wait_ff && (avs_read || avs_write)) begin
      wait_ff <= 1'b0;
      rdata_ff <= rd_mux;
    end else begin
      wait_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      filter_sel_ff <= `DIC_FILTER_RST;
      inv_ff <= `DIC_INV_RST;
      ptr_ff <= 10'h000;
      for (int i = 0; i < `DIC_NUM_IN; i++) begin
        func_ff[i] <= 5'h00;
        arg_ff[i] <= 3'h0;
      end
    end else if (wr_acc) begin
      if (reg_addr == `DIC_REG_FILTER) begin
        filter_sel_ff <= 14'((filter_sel_ff & ~wmask) |
          (avs_writedata & wmask));
      end
      if (reg_addr == `DIC_REG_INV && avs_byteenable[0]) begin
        inv_ff <= avs_writedata[6:0];
      end
      if (reg_addr == `DIC_REG_CMDPTR) begin
        ptr_ff <= 10'((ptr_ff & ~wmask) | (avs_writedata & wmask));
      end
      if (reg_addr == `DIC_REG_CMDDATA && avs_byteenable[0]) begin
        ptr_ff <= {ptr_ff[9:7], ptr_ff[6:0] + 7'h01};
      end
      for (int i = 0; i < `DIC_NUM_IN; i++) begin
        if (reg_addr == `DIC_REG_CFG0 + 8'(4 * i)) begin
          if (avs_byteenable[0]) func_ff[i] <= avs_writedata[4:0];
          if (avs_byteenable[1]) arg_ff[i] <= avs_writedata[10:8];
        end
      end
    end
  end

  // Buffers start empty; a length above 128 is held to 128.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 8; i++) begin
        len_ff[i] <= 8'h00;
      end
    end else if (wr_acc && reg_addr == `DIC_REG_CMDLEN &&
        avs_byteenable[0]) begin
      len_ff[ptr_ff[9:7]] <= (avs_writedata[7:0] > `DIC_BUF_CHARS) ?
        `DIC_BUF_CHARS : avs_writedata[7:0];
    end
  end

  assign mif.we = wr_acc && reg_addr == `DIC_REG_CMDDATA &&
    avs_byteenable[0];
  assign mif.waddr = ptr_ff;
  assign mif.wdata = avs_writedata[7:0];
  assign mif.re = st_ff == dic_pkg::DIC_S_ADDR;
  assign mif.raddr = {buf_ff, idx_ff};

  dic_cmd_mem u_mem (
    .clk(clk),
    .resetn(resetn),
    .mif(mif)
  );

  // ========================================================================
  // Command player: lowest input first, its rising event over its falling.
  always_comb begin
    pick_ok = 1'b0;
    pick_fall = 1'b0;
    pick_src = 3'h0;
    for (int i = `DIC_NUM_IN - 1; i >= 0; i--) begin
      if (rise_pend_ff[i] || fall_pend_ff[i]) begin
        pick_ok = 1'b1;
        pick_src = 3'(i);
        pick_fall = !rise_pend_ff[i];
      end
    end
  end
  assign pick_arg = arg_ff[pick_src];
  assign pick_buf = {2'(pick_arg - 3'h1), pick_fall};
  assign pick_go = pick_ok && pick_arg != 3'h0 &&
    pick_arg <= `DIC_ARG_MAX && len_ff[pick_buf] != 8'h00;

  always_comb begin
    clr_pend = 7'h00;
    if (st_ff == dic_pkg::DIC_S_IDLE && pick_ok) begin
      clr_pend[pick_src] = 1'b1;
    end
  end

  // An input with both events pending plays rise; its pending fall is cleared in the same pick.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= dic_pkg::DIC_S_IDLE;
      buf_ff <= 3'h0;
      idx_ff <= 7'h00;
      src_ff <= 3'h0;
    end else begin
      unique case (st_ff)
        dic_pkg::DIC_S_IDLE: begin
          if (pick_go) begin
            st_ff <= dic_pkg::DIC_S_ADDR;
            buf_ff <= pick_buf;
            src_ff <= pick_src;
            idx_ff <= 7'h00;
          end
        end
        dic_pkg::DIC_S_ADDR: st_ff <= dic_pkg::DIC_S_DATA;
        dic_pkg::DIC_S_DATA: st_ff <= dic_pkg::DIC_S_SEND;
        dic_pkg::DIC_S_SEND: begin
          if (cmd_ready) begin
            idx_ff <= idx_ff + 7'h01;
            st_ff <= last_ff ? dic_pkg::DIC_S_IDLE : dic_pkg::DIC_S_ADDR;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      char_ff <= 8'h00;
      valid_ff <= 1'b0;
      last_ff <= 1'b0;
    end else if (st_ff == dic_pkg::DIC_S_DATA) begin
      char_ff <= mif.rdata;
      valid_ff <= 1'b1;
      last_ff <= {1'b0, idx_ff} == len_ff[buf_ff] - 8'h01;
    end else if (st_ff == dic_pkg::DIC_S_SEND && cmd_ready) begin
      valid_ff <= 1'b0;
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign cmd_char = char_ff;
  assign cmd_valid = valid_ff;
  assign cmd_last = last_ff;
  assign cmd_src = src_ff;
  assign cmd_falling = buf_ff[0];

  // ========================================================================
  // Checks
  sequence s_start;
    st_ff == dic_pkg::DIC_S_IDLE && pick_go;
  endsequence
  sequence s_first_char;
    ##3 valid_ff && idx_ff == 7'h00;
  endsequence

  property p_start_plays;
    @(posedge clk) disable iff (!resetn)
    s_start |-> s_first_char;
  endproperty
  a_start_plays: assert property (p_start_plays)
    else $error("Started string did not present its first character.");

  property p_set_select;
    @(posedge clk) disable iff (!resetn)
    s_start |=> buf_ff[2:1] == 2'($past(pick_arg) - 3'h1) &&
      buf_ff[0] == $past(pick_fall);
  endproperty
  a_set_select: assert property (p_set_select)
    else $error("Wrong buffer set chosen for the input.");

  property p_rise_event;
    @(posedge clk) disable iff (!resetn)
    (active & ~prev_ff & armed) != 7'h00 |=> rise_pend_ff != 7'h00;
  endproperty
  a_rise_event: assert property (p_rise_event)
    else $error("Qualified rising edge was not recorded.");

  property p_fall_event;
    @(posedge clk) disable iff (!resetn)
    (~active & prev_ff & armed) != 7'h00 |=> fall_pend_ff != 7'h00;
  endproperty
  a_fall_event: assert property (p_fall_event)
    else $error("Qualified falling edge was not recorded.");

  property p_char_hold;
    @(posedge clk) disable iff (!resetn)
    valid_ff && !cmd_ready |=> valid_ff && $stable(char_ff) &&
      $stable(last_ff);
  endproperty
  a_char_hold: assert property (p_char_hold)
    else $error("Character dropped before it was taken.");

  property p_within_len;
    @(posedge clk) disable iff (!resetn)
    valid_ff |-> {1'b0, idx_ff} < len_ff[buf_ff];
  endproperty
  a_within_len: assert property (p_within_len)
    else $error("Character index beyond the buffer length.");

  property p_rotary_range;
    @(posedge clk) disable iff (!resetn)
    rotary_ff <= 7'd99;
  endproperty
  a_rotary_range: assert property (p_rotary_range)
    else $error("Rotary value above 99.");

  property p_states_order;
    @(posedge clk) disable iff (!resetn)
    ##1 states_ff[6] == $past(filt[0]) && states_ff[0] == $past(filt[6]);
  endproperty
  a_states_order: assert property (p_states_order)
    else $error("State vector bit order wrong.");

  property p_polarity;
    @(posedge clk) disable iff (!resetn)
    ##1 prev_ff == $past(filt ^ inv_ff);
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("Active level does not follow the polarity setting.");

  property p_wait_one;
    @(posedge clk) disable iff (!resetn)
    !wait_ff |=> wait_ff;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("Waitrequest stayed low for more than one cycle.");
endmodule : dic_top

//--- dv/dic_pin_model.sv
// Model of the switches and knob wired to the input pins.
`timescale 1ns/1ns
module dic_pin_model (
  clk,
  din_pin,
  rot_tens_pin,
  rot_ones_pin
);
  input wire logic clk;
  output logic [6:0] din_pin;
  output logic [3:0] rot_tens_pin;
  output logic [3:0] rot_ones_pin;
  // ==========================================================================
  // Drivers
  // Switch contacts are always driven, so the pins never float.
  initial begin
    din_pin = 7'h00;
    rot_tens_pin = 4'h0;
    rot_ones_pin = 4'h0;
  end
  task automatic set_pin(input int idx, input logic val);
    din_pin[idx] <= val;
  endtask : set_pin
  task automatic set_all(input logic [6:0] val);
    din_pin <= val;
  endtask : set_all
  task automatic set_knob(input logic [3:0] t, input logic [3:0] o);
    rot_tens_pin <= t;
    rot_ones_pin <= o;
  endtask : set_knob
endmodule : dic_pin_model

//--- dv/dic_top_tb.sv
// Self-checking bench of the input conditioning unit.
`timescale 1ns/1ns
`include "dic_consts.svh"
module dic_top_tb;
  localparam logic [15:0] F3 = 16'h0028;
  logic clk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic cmd_ready = 1'b0, cmd_valid, cmd_last, cmd_falling, avs_waitrequest;
  logic [7:0] avs_address = 8'h00, cmd_char;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] avs_byteenable = 4'hf, rot_tens_pin, rot_ones_pin;
  logic [6:0] din_pin, pat;
  logic [2:0] cmd_src;
  int fails = 0, tests_run = 0;
  always #25 clk = ~clk;
  always @(posedge clk) cmd_ready <= 1'($urandom);
  dic_top #(.FILT3_CYC(F3)) u_dic_top (.clk(clk), .resetn(resetn),
    .din_pin(din_pin), .rot_tens_pin(rot_tens_pin),
    .rot_ones_pin(rot_ones_pin), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cmd_ready(cmd_ready), .cmd_char(cmd_char), .cmd_valid(cmd_valid),
    .cmd_last(cmd_last), .cmd_src(cmd_src), .cmd_falling(cmd_falling));
  dic_pin_model u_dic_pin_model (.clk(clk), .din_pin(din_pin),
    .rot_tens_pin(rot_tens_pin), .rot_ones_pin(rot_ones_pin));
  // ==========================================================================
  // Helpers
  task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic bus(input logic do_wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    if (do_wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd_chk(input string name, input logic [7:0] a,
      input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(name, q, exp);
  endtask : rd_chk
  function automatic logic [31:0] knob(input int t, input int o);
    return 32'((t > 9 ? 9 : t) * 10 + (o > 9 ? 9 : o));
  endfunction : knob
  function automatic logic [31:0] states(input logic [6:0] p);
    logic [31:0] r = 32'h0;
    for (int i = 0; i < 7; i++) r[6 - i] = p[i];
    return r;
  endfunction : states
  function automatic logic [7:0] chr(input int b, input int k);
    return 8'(8'h30 + b * 8 + k);
  endfunction : chr
  task automatic get_str(input int b, input int src, input logic fall);
    for (int k = 0; k < 3; k++) begin
      do begin
        @(posedge clk);
      end while (!(cmd_valid === 1'b1 && cmd_ready));
      check("cmd", {cmd_char, cmd_last, 1'(0), cmd_src, cmd_falling},
        {chr(b, k), k == 2, 1'(0), 3'(src), fall});
    end
  endtask : get_str
  // ==========================================================================
  // Tests
  initial begin
    int t, o, i, w, n;
    int nf[3] = '{205, 3260, 40};
    int lo[3] = '{180, 3000, 30};
    int hi[3] = '{230, 3500, 50};
    void'($urandom(32'hb717));
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rd_chk("filter", `DIC_REG_FILTER, 32'(`DIC_FILTER_RST));
    rd_chk("polarity", `DIC_REG_INV, 32'(`DIC_INV_RST));
    rd_chk("length", `DIC_REG_CMDLEN, 32'h0);
    rd_chk("unmapped", 8'hfc, 32'h0);
    avs_byteenable <= 4'he;
    wr(`DIC_REG_FILTER, 32'h0);
    avs_byteenable <= 4'hf;
    rd_chk("lanes", `DIC_REG_FILTER,
      32'(`DIC_FILTER_RST) & 32'hff);
    wr(`DIC_REG_CMDPTR, 32'h380);
    wr(`DIC_REG_CMDLEN, 32'hc8);
    rd_chk("clamp", `DIC_REG_CMDLEN, 32'(`DIC_BUF_CHARS));
    for (int k = 0; k < 8; k++) begin
      t = (k == 0) ? 9 : (k == 1) ? 15 : $urandom % 10;
      o = (k == 0) ? 9 : (k == 1) ? 0 : $urandom % 10;
      u_dic_pin_model.set_knob(4'(t), 4'(o));
      repeat (6) @(posedge clk);
      rd_chk("knob", `DIC_REG_ROTARY, knob(t, o));
    end
    wr(`DIC_REG_FILTER, 32'h0);
    for (int k = 0; k < 8; k++) begin
      pat = (k == 0) ? 7'h01 : (k == 1) ? 7'h7f : 7'($urandom);
      u_dic_pin_model.set_all(pat);
      repeat (6) @(posedge clk);
      rd_chk("states", `DIC_REG_STATES, states(pat));
    end
    u_dic_pin_model.set_all(7'h00);
    for (int s = 0; s < 3; s++) begin
      wr(`DIC_REG_FILTER, 32'(s + 1));
      repeat (nf[s] + 10) @(posedge clk);
      for (int acc = 0; acc < 2; acc++) begin
        w = acc ? hi[s] : lo[s];
        u_dic_pin_model.set_pin(0, 1'b1);
        repeat (w) @(posedge clk);
        if (!acc) u_dic_pin_model.set_pin(0, 1'b0);
        rd_chk("width", `DIC_REG_STATES,
          acc ? 32'h40 : 32'h0);
        u_dic_pin_model.set_pin(0, 1'b0);
        repeat (nf[s] + 10) @(posedge clk);
      end
    end
    wr(`DIC_REG_FILTER, 32'h0);
    for (int b = 0; b < 8; b++) begin
      wr(`DIC_REG_CMDPTR, 32'(b << 7));
      for (int k = 0; k < 3; k++) wr(`DIC_REG_CMDDATA, 32'(chr(b, k)));
      wr(`DIC_REG_CMDLEN, 32'h3);
    end
    for (int s = 1; s <= 4; s++) begin
      i = $urandom % 7;
      wr(`DIC_REG_INV, 32'((s % 2) << i));
      wr(8'(`DIC_REG_CFG0 + 4 * i), 32'((s << 8) | `DIC_FN_CMDBUF));
      u_dic_pin_model.set_pin(i, 1'b1);
      get_str(2 * (s - 1) + (s % 2), i, 1'(s % 2));
      u_dic_pin_model.set_pin(i, 1'b0);
      get_str(2 * (s - 1) + 1 - (s % 2), i, 1'(1 - s % 2));
      wr(8'(`DIC_REG_CFG0 + 4 * i), 32'h0);
      wr(`DIC_REG_INV, 32'h0);
    end
    for (int a = 0; a < 2; a++) begin
      wr(`DIC_REG_CFG0, 32'(((a ? 5 : 0) << 8) | `DIC_FN_CMDBUF));
      u_dic_pin_model.set_pin(0, 1'b1);
      n = 0;
      repeat (30) @(posedge clk) n += (cmd_valid !== 1'b0);
      check("disarmed", 32'(n), 32'h0);
      u_dic_pin_model.set_pin(0, 1'b0);
      repeat (30) @(posedge clk);
    end
    results();
  end
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    results();
  end
endmodule : dic_top_tb
